// ==== logic/kef_top.sv ====
// Key event queue read port and keyscan configuration register.
// Assumes a serial bus engine issues one-cycle register requests on CLK,
// and the scan engine offers debounced events with valid/ready.
`timescale 1ns/1ns
`default_nettype none
module kef_top (
    input wire logic CLK,
    input wire logic RSTN,
    input wire kef_pkg::kef_req_t REQ,
    output logic [7:0] RDATA,
    output logic RVALID,
    input wire logic EV_VALID,
    output logic EV_READY,
    input wire kef_pkg::kef_event_t EV_DATA,
    input wire logic PWM_CC_EN,
    input wire logic AUTOSLEEP,
    input wire logic SLEEP_EXIT,
    output logic SLEEP,
    output logic TIMEOUT_DIS,
    output logic KEY_EVENT_IRQ_N
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [1:0] pwm_sync_reg;
    logic pwm_en;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) rst_sync_reg <= 2'h0;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // PWM enable comes from another block domain-free; treat as a pin
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) pwm_sync_reg <= 2'h0;
        else pwm_sync_reg <= {pwm_sync_reg[0], PWM_CC_EN};
    end
    assign pwm_en = pwm_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Configuration register
    logic [6:0] cfg_lo_reg;
    logic sleep_reg;
    logic [7:0] cfg_reg;
    logic cfg_wr;
    logic rd_q;
    logic key_press_in;

    assign cfg_wr = REQ.wr && (REQ.addr == kef_pkg::KEF_OFS_CONFIG);
    assign rd_q = REQ.rd && (REQ.addr == kef_pkg::KEF_OFS_QUEUE);
    // Sleep and the other bits live in separate registers, one writer each
    assign cfg_reg = {sleep_reg, cfg_lo_reg};

    // Non-sleep bits written directly; reserved bits masked to zero
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg_lo_reg <= kef_pkg::KEF_CFG_RESET[6:0];
        end else if (cfg_wr) begin
            cfg_lo_reg <= REQ.wdata[6:0] & kef_pkg::KEF_CFG_WMASK[6:0];
        end
    end

    // Sleep bit: host, autosleep, autowakeup; forced clear while PWM is on
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sleep_reg <= kef_pkg::KEF_CFG_RESET[kef_pkg::KEF_CFG_SLEEP];
        end else if (pwm_en) begin
            sleep_reg <= 1'b0;
        end else if (cfg_wr) begin
            sleep_reg <= REQ.wdata[kef_pkg::KEF_CFG_SLEEP];
        end else if (key_press_in && cfg_reg[kef_pkg::KEF_CFG_WAKE_EN]) begin
            sleep_reg <= 1'b0;
        end else if (SLEEP_EXIT) begin
            sleep_reg <= 1'b0;
        end else if (AUTOSLEEP) begin
            sleep_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry buffer on the event path
    logic sk_valid;
    logic sk_ready;
    kef_pkg::kef_event_t sk_data;
    logic ev_ready_w;

    kef_skid u_skid (
        .clk(CLK),
        .rst_n(rst_n),
        .in_valid(EV_VALID),
        .in_ready(ev_ready_w),
        .in_data(EV_DATA),
        .out_valid(sk_valid),
        .out_ready(sk_ready),
        .out_data(sk_data)
    );

    // Registered copy of ready for the port
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) EV_READY <= 1'b0;
        else EV_READY <= ev_ready_w;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event queue
    kef_pkg::kef_event_t mem [kef_pkg::KEF_DEPTH];
    logic [kef_pkg::KEF_AW:0] cnt_reg;
    logic [kef_pkg::KEF_AW-1:0] wp_reg;
    logic [kef_pkg::KEF_AW-1:0] rp_reg;
    logic ovf_reg;
    logic full;
    logic drop_rel;
    logic push;
    logic pop;
    logic accept;

    assign full = (cnt_reg == 5'(kef_pkg::KEF_DEPTH));
    assign drop_rel = sk_data.release_ev && !sk_data.repeat_ev && !cfg_reg[kef_pkg::KEF_CFG_REL_EN];
    // Queue drains while asleep too; events still arrive for wakeup
    assign sk_ready = 1'b1;
    assign accept = sk_valid;
    assign push = accept && !drop_rel && !full;
    assign pop = rd_q && (cnt_reg != '0);
    assign key_press_in = accept && !sk_data.release_ev && !sk_data.repeat_ev;

    // Count and pointers
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + {4'h0, push} - {4'h0, pop};
            if (push) wp_reg <= wp_reg + 4'h1;
            if (pop) rp_reg <= rp_reg + 4'h1;
        end
    end

    // Storage
    always_ff @(posedge CLK) begin
        if (push) mem[wp_reg] <= sk_data;
    end

    // Overflow flag: set on dropped event wins over clearing by its report
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) ovf_reg <= 1'b0;
        else if (accept && !drop_rel && full) ovf_reg <= 1'b1;
        else if (rd_q && cnt_reg == '0) ovf_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data encoding
    kef_pkg::kef_event_t head;
    logic more;
    logic [7:0] ev_byte;

    assign head = mem[rp_reg];
    assign more = (cnt_reg > 5'h1);

    always_comb begin
        if (cnt_reg == '0) begin
            ev_byte = {1'b0, ovf_reg, kef_pkg::KEF_KEY_ALL1};
        end else if (head.repeat_ev) begin
            ev_byte = {1'b0, more, kef_pkg::KEF_KEY_REPEAT};
        end else if (head.key >= kef_pkg::KEF_KEY_HIGH) begin
            ev_byte = {1'b1, head.release_ev, head.key};
        end else begin
            ev_byte = {more, head.release_ev, head.key};
        end
    end

    // Register read port, answer one cycle after request
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 8'h00;
            RVALID <= 1'b0;
        end else begin
            RVALID <= REQ.rd;
            if (REQ.rd) begin
                if (REQ.addr == kef_pkg::KEF_OFS_QUEUE) RDATA <= ev_byte;
                else if (REQ.addr == kef_pkg::KEF_OFS_CONFIG) RDATA <= cfg_reg;
                else RDATA <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Key interrupt and status outputs
    logic irq_ack_reg;

    // In read-clear mode a host queue read acknowledges; new push re-arms
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) irq_ack_reg <= 1'b0;
        else if (push) irq_ack_reg <= 1'b0;
        else if (rd_q) irq_ack_reg <= 1'b1;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            KEY_EVENT_IRQ_N <= 1'b1;
            SLEEP <= 1'b0;
            TIMEOUT_DIS <= 1'b0;
        end else begin
            if (cfg_reg[kef_pkg::KEF_CFG_IRQ_ON_READ]) KEY_EVENT_IRQ_N <= !(cnt_reg != '0 && !irq_ack_reg);
            else KEY_EVENT_IRQ_N <= (cnt_reg == '0);
            SLEEP <= cfg_reg[kef_pkg::KEF_CFG_SLEEP] && !pwm_en;
            TIMEOUT_DIS <= cfg_reg[kef_pkg::KEF_CFG_TMO_DIS];
        end
    end
endmodule : kef_top
`default_nettype wire

// ==== logic/kef_pkg.sv ====
// Package for the key event queue and keyscan configuration block.
// Assumes a single clock domain; used by logic/kef_top.sv and logic/kef_skid.sv.
package kef_pkg;
    // Register offsets
    localparam logic [7:0] KEF_OFS_QUEUE = 8'h00;
    localparam logic [7:0] KEF_OFS_CONFIG = 8'h01;
    // Configuration field positions
    localparam int KEF_CFG_SLEEP = 7;
    localparam int KEF_CFG_IRQ_ON_READ = 5;
    localparam int KEF_CFG_REL_EN = 3;
    localparam int KEF_CFG_WAKE_EN = 1;
    localparam int KEF_CFG_TMO_DIS = 0;
    localparam logic [7:0] KEF_CFG_WMASK = 8'hab;
    localparam logic [7:0] KEF_CFG_RESET = 8'h0a;
    // Event byte fields
    localparam int KEF_EV_MORE = 7;
    localparam int KEF_EV_REL = 6;
    localparam logic [5:0] KEF_KEY_ALL1 = 6'h3f;
    localparam logic [5:0] KEF_KEY_REPEAT = 6'h3e;
    localparam logic [5:0] KEF_KEY_HIGH = 6'h3e;
    // Queue depth
    localparam int KEF_DEPTH = 16;
    localparam int KEF_AW = 4;

    // One key event as delivered by the scan engine
    typedef struct packed {
        logic repeat_ev;
        logic release_ev;
        logic [5:0] key;
    } kef_event_t;

    // Register access from the serial bus engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kef_req_t;
endpackage : kef_pkg

// ==== logic/kef_skid.sv ====
// Two-entry buffer between the scan engine and the event queue.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/1ns
`default_nettype none
module kef_skid (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire kef_pkg::kef_event_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output kef_pkg::kef_event_t out_data
);
    kef_pkg::kef_event_t buf_reg [2];
    logic [1:0] cnt_reg;
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic push;
    logic pop;

    // Handshakes on both sides
    assign push = in_valid && (cnt_reg != 2'h2);
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = buf_reg[rd_ptr_reg];

    // Occupancy and pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 2'h0;
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) buf_reg[wr_ptr_reg] <= in_data;
    end
endmodule : kef_skid
`default_nettype wire

// ==== sim/kef_checker.sv ====
// Port checker for kef_top.
// Assumes the bind below; one clock, RSTN low resets.
`timescale 1ns/1ns
`default_nettype none
module kef_checker (
    input wire logic CLK,
    input wire logic RSTN,
    input wire kef_pkg::kef_req_t REQ,
    input wire logic [7:0] RDATA,
    input wire logic RVALID,
    input wire logic PWM_CC_EN,
    input wire logic SLEEP,
    input wire logic TIMEOUT_DIS,
    input wire logic KEY_EVENT_IRQ_N
);
    logic cfg5_reg;
    logic [3:0] pwm_reg;
    logic [7:0] addr_reg;
    wire rdq = RVALID && addr_reg == 8'h00;
    wire rdc = RVALID && addr_reg == 8'h01;
    wire cfgw = REQ.wr && REQ.addr == 8'h01;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Interrupt mode, PWM history and last read address
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg5_reg <= 1'b0;
            pwm_reg <= 4'h0;
            addr_reg <= 8'h00;
        end else begin
            if (cfgw) cfg5_reg <= REQ.wdata[5];
            pwm_reg <= {pwm_reg[2:0], PWM_CC_EN};
            if (REQ.rd) addr_reg <= REQ.addr;
        end
    end
    ////////////////////////////////////////////////////////////
    // Bus, sleep and interrupt relations
    a_read_answer: assert property (REQ.rd |=> RVALID)
        else $error("read unanswered");
    a_reserved_zero: assert property (rdc |-> !RDATA[6] && !RDATA[4] && !RDATA[2])
        else $error("reserved bit set");
    a_timeout_bit: assert property (cfgw |-> ##2 TIMEOUT_DIS == $past(REQ.wdata[0], 2))
        else $error("timeout bit wrong");
    a_pwm_awake: assert property (PWM_CC_EN [*4] |-> !SLEEP)
        else $error("sleep under pwm");
    a_host_sleep: assert property (pwm_reg == 4'h0 && !PWM_CC_EN && cfgw |-> ##2 SLEEP == $past(REQ.wdata[7], 2))
        else $error("sleep write lost");
    a_sleep_readback: assert property (rdc && pwm_reg == 4'h0 |-> RDATA[7] == SLEEP)
        else $error("sleep readback");
    a_empty_irq: assert property (rdq && RDATA == 8'h3f && !cfg5_reg |-> ##[0:2] KEY_EVENT_IRQ_N)
        else $error("irq after empty");
    a_irq_on_read: assert property (cfg5_reg && REQ.rd && REQ.addr == 8'h00 |-> ##[1:3] KEY_EVENT_IRQ_N)
        else $error("irq kept");
    c_empty: cover property (rdq && RDATA == 8'h3f);
    c_overflow: cover property (rdq && RDATA == 8'h7f);
    c_sleep: cover property ($rose(SLEEP));
endmodule : kef_checker
bind kef_top kef_checker u_kef_checker (.CLK(CLK), .RSTN(RSTN), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID),
    .PWM_CC_EN(PWM_CC_EN), .SLEEP(SLEEP), .TIMEOUT_DIS(TIMEOUT_DIS), .KEY_EVENT_IRQ_N(KEY_EVENT_IRQ_N));
`default_nettype wire

// ==== sim/kef_host.sv ====
// Host model on the register request port.
// Assumes one-cycle requests taken on rising CLK.
`timescale 1ns/1ns
`default_nettype none
module kef_host (
    input wire logic CLK,
    output kef_pkg::kef_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial req = '0;
    // One request pulse, answer taken one edge later
    task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] w, output logic [7:0] d);
        req <= {r, !r, a, w};
        @(posedge CLK);
        req <= '0;
        @(posedge CLK);
        d = rvalid === r ? rdata : 8'hxx;
    endtask : xfer
    // Keep reading the queue until the empty code shows
    task automatic drain;
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 20 && d != 8'h3f; i++) xfer(1'b1, 8'h00, 8'h00, d);
    endtask : drain
endmodule : kef_host
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for kef_top.
// Assumes kef_host drives the bus and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %0t got %h want %h", $time, g, e); end end
module tb_top;
    logic CLK, RSTN, EV_VALID, EV_READY, PWM_CC_EN, AUTOSLEEP, SLEEP_EXIT, SLEEP, TIMEOUT_DIS, IRQ_N, RVALID;
    logic [7:0] RDATA, d;
    kef_pkg::kef_req_t REQ;
    kef_pkg::kef_event_t EV_DATA;
    kef_pkg::kef_event_t ev_q[5] = '{8'h05, 8'h49, 8'h80, 8'h3e, 8'h7f};
    logic [7:0] exp_q[5] = '{8'h85, 8'hc9, 8'h7e, 8'hbe, 8'hff};
    int num_errors, cmp_count;
    kef_top u_kef_top (.CLK(CLK), .RSTN(RSTN), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID), .EV_VALID(EV_VALID),
        .EV_READY(EV_READY), .EV_DATA(EV_DATA), .PWM_CC_EN(PWM_CC_EN), .AUTOSLEEP(AUTOSLEEP),
        .SLEEP_EXIT(SLEEP_EXIT), .SLEEP(SLEEP), .TIMEOUT_DIS(TIMEOUT_DIS), .KEY_EVENT_IRQ_N(IRQ_N));
    kef_host u_kef_host (.CLK(CLK), .req(REQ), .rdata(RDATA), .rvalid(RVALID));
    // Clock
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_kef_host.xfer(1'b1, a, 8'h00, d);
        `CHK(d, e)
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        u_kef_host.xfer(1'b0, a, w, d);
    endtask : wr
    // Offer one event until the buffer takes it
    task automatic push(input kef_pkg::kef_event_t e);
        EV_VALID <= 1'b1;
        EV_DATA <= e;
        @(posedge CLK);
        while (EV_READY !== 1'b1) @(posedge CLK);
        EV_VALID <= 1'b0;
        @(posedge CLK);
    endtask : push
    task automatic summarize;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // Watchdog
    initial begin
        repeat (5000) @(posedge CLK);
        num_errors++;
        summarize();
    end
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        RSTN = 1'b0;
        EV_VALID = 1'b0;
        EV_DATA = '0;
        PWM_CC_EN = 1'b0;
        AUTOSLEEP = 1'b0;
        SLEEP_EXIT = 1'b0;
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge CLK);
        rd(8'h01, 8'h0a);
        rd(8'h00, 8'h3f);
        rd(8'h05, 8'h00);
        `CHK(EV_READY, 1'b1)
        wr(8'h01, 8'hff);
        rd(8'h01, 8'hab);
        `CHK(TIMEOUT_DIS, 1'b1)
        wr(8'h01, 8'h0a);
        foreach (ev_q[i]) push(ev_q[i]);
        repeat (3) @(posedge CLK);
        `CHK(IRQ_N, 1'b0)
        foreach (exp_q[i]) rd(8'h00, exp_q[i]);
        rd(8'h00, 8'h3f);
        repeat (3) @(posedge CLK);
        `CHK(IRQ_N, 1'b1)
        // Releases dropped when reporting is off
        wr(8'h01, 8'h02);
        push(8'h44);
        push(8'h04);
        repeat (3) @(posedge CLK);
        rd(8'h00, 8'h04);
        rd(8'h00, 8'h3f);
        // Overflow in read-clear mode
        wr(8'h01, 8'h2a);
        for (int i = 0; i < 17; i++) push({2'b00, 6'(i)});
        repeat (3) @(posedge CLK);
        `CHK(IRQ_N, 1'b0)
        rd(8'h00, 8'h80);
        repeat (2) @(posedge CLK);
        `CHK(IRQ_N, 1'b1)
        for (int i = 1; i < 16; i++) rd(8'h00, {i < 15, 1'b0, 6'(i)});
        rd(8'h00, 8'h7f);
        rd(8'h00, 8'h3f);
        // Sleep by host, exit, autosleep, keypress wake, PWM lock
        wr(8'h01, 8'h8a);
        @(posedge CLK);
        `CHK(SLEEP, 1'b1)
        rd(8'h01, 8'h8a);
        SLEEP_EXIT <= 1'b1;
        @(posedge CLK);
        SLEEP_EXIT <= 1'b0;
        repeat (2) @(posedge CLK);
        `CHK(SLEEP, 1'b0)
        AUTOSLEEP <= 1'b1;
        @(posedge CLK);
        AUTOSLEEP <= 1'b0;
        repeat (2) @(posedge CLK);
        `CHK(SLEEP, 1'b1)
        push(8'h07);
        repeat (4) @(posedge CLK);
        `CHK(SLEEP, 1'b0)
        u_kef_host.drain();
        PWM_CC_EN <= 1'b1;
        repeat (4) @(posedge CLK);
        wr(8'h01, 8'h8a);
        @(posedge CLK);
        `CHK(SLEEP, 1'b0)
        rd(8'h01, 8'h0a);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
